//--- verilog/csc_pkg.sv
// shared constants and types for the configuration status chain controller
package csc_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    // power-on reset interval, in microseconds
    localparam int unsigned POR_TIME_US   = 100;
    localparam int unsigned POR_CYCLES    =
        (POR_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
        POR_TIME_US * (CLK_HZ / 1_000_000);
    // initialization cycle length, in clock cycles
    localparam int unsigned INIT_CYCLES   = 16;
    localparam int unsigned CNT_W         = 16;
    // serial memory read command, shifted msb first
    localparam logic [7:0]  MEM_READ_CMD  = 8'h03;
    localparam int unsigned CMD_BITS      = 8;

    typedef enum logic [2:0] {
        CSC_POR,
        CSC_IDLE,
        CSC_LOAD,
        CSC_WAIT_DONE,
        CSC_INIT,
        CSC_USER,
        CSC_ERROR
    } csc_state_t;
endpackage : csc_pkg

//--- verilog/csc_pin_if.sv
// open-drain pin carrier between the controller and its pin stage
`timescale 1ns/1ps
interface csc_pin_if;
    logic pin_in;
    logic pull_low;
    logic pin_out;
    logic pin_oe;
    logic pin_sync;
    modport ctrl (output pull_low, input pin_sync);
    modport pad  (input pull_low, input pin_in,
                  output pin_out, output pin_oe, output pin_sync);
endinterface : csc_pin_if

//--- verilog/csc_od_pin.sv
// open-drain pin stage with a two-flop input synchroniser
`timescale 1ns/1ps
module csc_od_pin (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    csc_pin_if.pad    pin
);
    logic meta_r;
    logic sync_r;

    // output side only ever drives zero
    assign pin.pin_out  = 1'b0;
    assign pin.pin_oe   = pin.pull_low;
    assign pin.pin_sync = sync_r;

    // resets high, matching an idle pulled-up line
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= pin.pin_in;
            sync_r <= meta_r;
        end
    end
endmodule : csc_od_pin

//--- verilog/csc_ctrl.sv
// configuration status and chain control state machine
`timescale 1ns/1ps
module csc_ctrl
    import csc_pkg::*;
#(
    parameter int unsigned POR_CNT = POR_CYCLES
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_chain_en_n,
    input  wire logic i_cfg_ctrl_n,
    input  wire logic i_active_serial_boot,
    input  wire logic i_data_valid,
    input  wire logic i_data_last,
    input  wire logic i_data_err,
    input  wire logic i_status_in,
    output logic      o_status_out,
    output logic      o_status_oe,
    input  wire logic i_done_in,
    output logic      o_config_complete_flag_out,
    output logic      o_config_complete_flag_oe,
    output logic      o_chain_en_n,
    output logic      o_load_ready,
    output logic      o_serial_mem_cmd_out,
    output logic      o_serial_mem_sel_n,
    output logic      o_user_mode,
    output logic      o_io_tristate,
    output logic      o_cfg_error
);
    csc_pin_if status_pin ();
    csc_pin_if done_pin ();

    csc_state_t        state_r;
    csc_state_t        state_nxt;
    logic [CNT_W-1:0]  por_cnt_r;
    logic [CNT_W-1:0]  init_cnt_r;
    logic [3:0]        cmd_cnt_r;
    logic [7:0]        cmd_sr_r;
    logic              chain_meta_r;
    logic              chain_sync_r;
    logic              ctrl_meta_r;
    logic              ctrl_sync_r;
    logic              boot_meta_r;
    logic              boot_sync_r;
    logic              chain_en_n_r;
    logic              mem_cmd_r;
    logic              mem_sel_n_r;
    logic              por_done;
    logic              status_ok;

    assign status_pin.pin_in = i_status_in;
    assign done_pin.pin_in   = i_done_in;

    csc_od_pin u_status (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .pin     (status_pin)
    );
    csc_od_pin u_done (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .pin     (done_pin)
    );

    assign o_status_out               = status_pin.pin_out;
    assign o_status_oe                = status_pin.pin_oe;
    assign o_config_complete_flag_out = done_pin.pin_out;
    assign o_config_complete_flag_oe  = done_pin.pin_oe;

    // pin-level control inputs, two flops each
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            chain_meta_r <= 1'b1;
            chain_sync_r <= 1'b1;
            ctrl_meta_r  <= 1'b0;
            ctrl_sync_r  <= 1'b0;
            boot_meta_r  <= 1'b0;
            boot_sync_r  <= 1'b0;
        end else begin
            chain_meta_r <= i_chain_en_n;
            chain_sync_r <= chain_meta_r;
            ctrl_meta_r  <= i_cfg_ctrl_n;
            ctrl_sync_r  <= ctrl_meta_r;
            boot_meta_r  <= i_active_serial_boot;
            boot_sync_r  <= boot_meta_r;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            por_cnt_r <= '0;
        end else if (por_cnt_r != CNT_W'(POR_CNT)) begin
            por_cnt_r <= por_cnt_r + 1'b1;
        end
    end
    assign por_done  = (por_cnt_r == CNT_W'(POR_CNT));
    assign status_ok = status_pin.pin_sync;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            CSC_POR:
                if (por_done) begin
                    state_nxt = CSC_IDLE;
                end
            CSC_IDLE:
                if (ctrl_sync_r && status_ok && !chain_sync_r) begin
                    state_nxt = CSC_LOAD;
                end
            CSC_LOAD:
                if (i_data_err || !status_ok) begin
                    state_nxt = CSC_ERROR;
                end else if (!ctrl_sync_r) begin
                    state_nxt = CSC_IDLE;
                end else if (i_data_valid && i_data_last && !chain_sync_r) begin
                    state_nxt = CSC_WAIT_DONE;
                end
            CSC_WAIT_DONE:
                if (!status_ok) begin
                    state_nxt = CSC_ERROR;
                end else if (!ctrl_sync_r) begin
                    state_nxt = CSC_IDLE;
                end else if (done_pin.pin_sync) begin
                    state_nxt = CSC_INIT;
                end
            CSC_INIT:
                if (!status_ok) begin
                    state_nxt = CSC_ERROR;
                end else if (!ctrl_sync_r) begin
                    state_nxt = CSC_IDLE;
                end else if (init_cnt_r == CNT_W'(INIT_CYCLES - 1)) begin
                    state_nxt = CSC_USER;
                end
            // flag and status ignored; only control reloads
            CSC_USER:
                if (!ctrl_sync_r) begin
                    state_nxt = CSC_IDLE;
                end
            CSC_ERROR:
                if (!ctrl_sync_r) begin
                    state_nxt = CSC_IDLE;
                end
            default:
                state_nxt = CSC_POR;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_r <= CSC_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            init_cnt_r <= '0;
        end else if (state_r == CSC_INIT) begin
            init_cnt_r <= init_cnt_r + 1'b1;
        end else begin
            init_cnt_r <= '0;
        end
    end

    // status pulled low before por and on error
    assign status_pin.pull_low = (state_r == CSC_POR) ||
                                 (state_r == CSC_ERROR);
    // flag held low in por, idle, load and error
    assign done_pin.pull_low   = (state_r == CSC_POR) ||
                                 (state_r == CSC_IDLE) ||
                                 (state_r == CSC_LOAD) ||
                                 (state_r == CSC_ERROR);

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            chain_en_n_r <= 1'b1;
        end else begin
            chain_en_n_r <= (state_r != CSC_USER);
        end
    end
    assign o_chain_en_n = chain_en_n_r;

    assign o_load_ready = (state_r == CSC_LOAD) && !chain_sync_r;

    // read command shifted to serial memory at load start
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            cmd_cnt_r   <= '0;
            cmd_sr_r    <= '0;
            mem_cmd_r   <= 1'b1;
            mem_sel_n_r <= 1'b1;
        end else if (state_r == CSC_IDLE && state_nxt == CSC_LOAD
                     && boot_sync_r) begin
            cmd_cnt_r   <= 4'(CMD_BITS);
            cmd_sr_r    <= MEM_READ_CMD;
            mem_sel_n_r <= 1'b0;
        end else if (state_r != CSC_LOAD) begin
            // idle level matches the pin pull-up
            cmd_cnt_r   <= '0;
            mem_cmd_r   <= 1'b1;
            mem_sel_n_r <= 1'b1;
        end else if (cmd_cnt_r != '0) begin
            mem_cmd_r   <= cmd_sr_r[7];
            cmd_sr_r    <= {cmd_sr_r[6:0], 1'b0};
            cmd_cnt_r   <= cmd_cnt_r - 1'b1;
        end else begin
            mem_cmd_r   <= 1'b1;
        end
    end
    assign o_serial_mem_cmd_out = mem_cmd_r;
    assign o_serial_mem_sel_n   = mem_sel_n_r;

    assign o_user_mode   = (state_r == CSC_USER);
    assign o_io_tristate = (state_r != CSC_USER);
    assign o_cfg_error   = (state_r == CSC_ERROR);

    por_status_low_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !por_done |-> o_status_oe)
        else $error("status released before por");
    load_flag_low_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        state_r == CSC_LOAD |-> o_config_complete_flag_oe)
        else $error("flag released during load");
    flag_release_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_r == CSC_LOAD && i_data_valid && i_data_last && !i_data_err
         && status_ok && ctrl_sync_r && !chain_sync_r)
        |=> !o_config_complete_flag_oe)
        else $error("flag not released after load");
    init_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_r == CSC_INIT && $past(state_r) == CSC_WAIT_DONE)
        |-> $past(done_pin.pin_sync))
        else $error("init without flag high");
    // user mode holds with flag low
    user_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_r == CSC_USER && ctrl_sync_r) |=> state_r == CSC_USER)
        else $error("user mode lost");
    load_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_r == CSC_LOAD && $past(state_r) == CSC_IDLE)
        |-> $past(!chain_sync_r && status_ok))
        else $error("load began without enable");
    chain_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(o_user_mode) |=> !o_chain_en_n)
        else $error("chain enable output not low");
    status_err_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_r == CSC_LOAD && !status_ok) |=> o_cfg_error ##1 o_status_oe)
        else $error("no error on status low");
    ctrl_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_r == CSC_USER && !ctrl_sync_r) |=> o_io_tristate)
        else $error("control low did not clear");
    mem_cmd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_r == CSC_IDLE && state_nxt == CSC_LOAD && boot_sync_r)
        |=> !o_serial_mem_sel_n ##1 (o_serial_mem_cmd_out == MEM_READ_CMD[7]))
        else $error("serial read command not issued");
endmodule : csc_ctrl

//--- verif/csc_mem_model.sv
// pull-ups on the status lines and a serial memory stand-in
`timescale 1ns/1ps
module csc_mem_model (
    input  wire logic       i_mclk,
    input  wire logic       i_sel_n,
    input  wire logic       i_cmd,
    input  wire logic       i_status_oe,
    input  wire logic       i_flag_oe,
    input  wire logic       i_hold_status,
    input  wire logic       i_hold_flag,
    output logic            o_status,
    output logic            o_flag,
    output logic [7:0]      o_cmd_byte,
    output logic            o_cmd_done
);
    logic [3:0] bit_cnt_r;
    assign o_status = !(i_status_oe || i_hold_status);
    assign o_flag = !(i_flag_oe || i_hold_flag);
    assign o_cmd_done = (bit_cnt_r == 4'h8);
    // command capture
    // start on the first low bit: the command line idles high
    always_ff @(negedge i_mclk) begin
        if (i_sel_n) begin
            bit_cnt_r <= 4'h0;
        end else if (!o_cmd_done && (bit_cnt_r != 4'h0 || !i_cmd)) begin
            bit_cnt_r  <= bit_cnt_r + 4'h1;
            o_cmd_byte <= {o_cmd_byte[6:0], i_cmd};
        end
    end
endmodule : csc_mem_model

//--- verif/tb.sv
// self-checking bench for the configuration status chain controller
`timescale 1ns/1ps
module tb;
    import csc_pkg::*;
    localparam int unsigned POR_N = 20;
    logic clk, rst_n, ce_n, ctrl_n, asb, vld, last, derr, h_st, h_fl;
    logic st, fl, st_oe, fl_oe, ceo_n, rdy, cmd, sel_n, user, tri_s, err;
    logic st_o, fl_o, cdone;
    logic [7:0] cbyte;
    int fails, check_count, n;
    csc_ctrl #(.POR_CNT(POR_N)) csc_ctrl_i (.i_mclk(clk), .i_rst_n(rst_n),
        .i_chain_en_n(ce_n), .i_cfg_ctrl_n(ctrl_n),
        .i_active_serial_boot(asb), .i_data_valid(vld), .i_data_last(last),
        .i_data_err(derr), .i_status_in(st), .o_status_out(st_o),
        .o_status_oe(st_oe), .i_done_in(fl), .o_config_complete_flag_out(fl_o),
        .o_config_complete_flag_oe(fl_oe), .o_chain_en_n(ceo_n),
        .o_load_ready(rdy), .o_serial_mem_cmd_out(cmd),
        .o_serial_mem_sel_n(sel_n), .o_user_mode(user),
        .o_io_tristate(tri_s), .o_cfg_error(err));
    csc_mem_model csc_mem_model_i (.i_mclk(clk), .i_sel_n(sel_n),
        .i_cmd(cmd), .i_status_oe(st_oe), .i_flag_oe(fl_oe),
        .i_hold_status(h_st), .i_hold_flag(h_fl), .o_status(st),
        .o_flag(fl), .o_cmd_byte(cbyte), .o_cmd_done(cdone));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string name, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic print_verdict;
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // loads nitems items; the flag line is held low by the far side
    task automatic do_load(input int nitems);
        for (n = 0; n < 20 && rdy !== 1'b1; n++) tick(1);
        chk("load_ready", rdy, 1'b1);
        tick(1);
        chk("sel_n", sel_n, 1'b0);
        for (n = 0; n < 30 && cdone !== 1'b1; n++) tick(1);
        chk("cmd_byte", cbyte, MEM_READ_CMD);
        for (int i = 0; i < nitems; i++) begin
            chk("flag_oe_load", fl_oe, 1'b1);
            vld  = 1'b1;
            last = (i == nitems - 1);
            tick(1);
        end
        vld  = 1'b0;
        last = 1'b0;
        tick(1);
        chk("flag_oe_rel", fl_oe, 1'b0);
    endtask : do_load
    task automatic por_check;
        tick(10);
        chk("status_oe_por", st_oe, 1'b1);
        chk("rdy_por", rdy, 1'b0);
        chk("chain_out_por", ceo_n, 1'b1);
        chk("status_out", st_o, 1'b0);
        chk("flag_out", fl_o, 1'b0);
        for (n = 0; n < 30 && st_oe !== 1'b0; n++) tick(1);
        chk("por_len_ok", 8'(n + 10 >= POR_N), 8'h1);
    endtask : por_check
    task automatic good_load;
        h_fl = 1'b1;
        do_load(3);
        tick(30);
        chk("user_early", user, 1'b0);
        h_fl = 1'b0;
        for (n = 0; n < 40 && user !== 1'b1; n++) tick(1);
        chk("init_len_ok", 8'(n >= INIT_CYCLES), 8'h1);
        tick(2);
        chk("chain_out", ceo_n, 1'b0);
        chk("tristate", tri_s, 1'b0);
        h_fl = 1'b1;
        h_st = 1'b1;
        tick(10);
        chk("user_kept", user, 1'b1);
        chk("no_error", err, 1'b0);
        h_fl = 1'b0;
        h_st = 1'b0;
    endtask : good_load
    // control pulse clears user mode; chain enable high blocks reload
    task automatic ctrl_pulse;
        ctrl_n = 1'b0;
        tick(6);
        chk("user_clr", user, 1'b0);
        chk("tri_clr", tri_s, 1'b1);
        ce_n   = 1'b1;
        ctrl_n = 1'b1;
        tick(10);
        chk("rdy_ce_high", rdy, 1'b0);
        ce_n = 1'b0;
    endtask : ctrl_pulse
    task automatic err_cases;
        tick(4);
        h_st = 1'b1;
        tick(6);
        chk("ext_err", err, 1'b1);
        h_st = 1'b0;
        tick(3);
        chk("err_status", st_oe, 1'b1);
        ctrl_n = 1'b0;
        asb    = 1'b0;
        tick(6);
        ctrl_n = 1'b1;
        for (n = 0; n < 20 && rdy !== 1'b1; n++) tick(1);
        derr = 1'b1;
        tick(3);
        chk("sel_n_passive", sel_n, 1'b1);
        chk("data_err", err, 1'b1);
        chk("data_err_st", st_oe, 1'b1);
        derr = 1'b0;
    endtask : err_cases
    initial begin
        fails = 0;
        check_count = 0;
        // first device of a chain: enable tied low
        {vld, last, derr, h_st, h_fl, ce_n} = 6'h0;
        {rst_n, ctrl_n, asb} = 3'h3;
        tick(20);
        rst_n = 1'b1;
        por_check();
        good_load();
        ctrl_pulse();
        good_load();
        ctrl_pulse();
        err_cases();
        print_verdict();
    end
    initial begin
        #400us;
        fails++;
        print_verdict();
    end
endmodule : tb
